// ==== src/mcip_pkg.sv ====
/*
 * constants and carrier types for the main/critical interrupt prioritizer.
 * assumes: included before the design; bit n of a printed msb-0 layout is data[31-n].
 */
package mcip_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_EXT_CTRL    = 12'h510;
	localparam logic [11:0] OFS_CRIT_MASK   = 12'h514;
	localparam logic [11:0] OFS_MAIN_PRI_LO = 12'h518;
	localparam logic [11:0] OFS_MAIN_PRI_HI = 12'h51c;
	localparam logic [11:0] OFS_ENC_STAT    = 12'h524;
	localparam logic [11:0] OFS_CRIT_ALL    = 12'h528;
	localparam logic [11:0] OFS_MAIN_ALL    = 12'h52c;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int EDGE_INDICATION_CLEAR_TOP  = 27;
	localparam int ETYPE_TOP = 23;
	localparam int MEE_BIT   = 12;
	localparam int EXT_PIN_ENABLE_TOP  = 11;
	localparam int CEB_BIT   = 0;
	localparam int CPRI_TOP  = 31;
	localparam int MASK_TOP  = 16;
	localparam int PSE_LSB   = 24;
	localparam int MSE_LSB   = 16;
	localparam int CSE_LSB   = 8;
	localparam int PSE_FLAG  = 29;
	localparam int MSE_FLAG  = 21;
	localparam int CSE_FLAG  = 10;
	localparam int CSA_TOP   = 27;
	// ---------------------------------------------------------------
	// write masks and reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] EXT_CTRL_WMASK  = 32'h00ff_1f01;
	localparam logic [31:0] CRIT_MASK_WMASK = 32'hff01_ffff;
	localparam logic [31:0] EXT_CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] CRIT_MASK_RST   = 32'h0000_0000;
	localparam logic [31:0] MAIN_PRI_RST    = 32'h0000_0000;
	// ---------------------------------------------------------------
	// pin sensing codes
	// ---------------------------------------------------------------
	localparam logic [1:0] ET_LEVEL_HI = 2'h0;
	localparam logic [1:0] ET_RISE     = 2'h1;
	localparam logic [1:0] ET_FALL     = 2'h2;
	localparam logic [1:0] ET_LEVEL_LO = 2'h3;
	// ---------------------------------------------------------------
	// sizes and carrier
	// ---------------------------------------------------------------
	localparam int N_MAIN = 17;
	localparam int N_PERI = 22;
	localparam int N_CRIT = 4;
	localparam int N_PIN  = 4;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} mcip_bus_req_t;
endpackage

// ==== src/mcip_prioritizer.sv ====
/*
 * main and critical interrupt prioritizer: main masks, main priority/bank,
 * peripheral low/high collection, encoded current status and re-evaluation.
 * assumes: source modules and peripheral mask/priority logic on ref_clk,
 * external pins asynchronous, register master per the plain strobe port.
 */
// Overview of operation
// [RULE1] one mask bit per main source
// [RULE2] masked source hidden from core and encoding
// [RULE3] pins 1-3 need mask and pin enable
// [RULE4] source 0 top priority, management output only
// [RULE5] 4-bit priority, top bit picks bank
// [RULE6] equal priority favours lower source number
// [RULE7] sources 1-16 in nibbles of two registers
// [RULE8] peripheral goes low or high collection
// [RULE9] sources 7 and 8 collect pin groups
// [RULE10] last two timers also wake sources
// [RULE11] peripheral encoding with presence flag
// [RULE12] hold current until input negates
// [RULE13] write one forces peripheral re-evaluation
// [RULE14] main encoding, flag write re-evaluates
// [RULE15] software parses peripheral code for source 4
// [RULE16] critical encoding of four sources
// [RULE17] bit 31 mirrors critical routing enable
// [RULE18] pins 1-3 edge cleared by one method; code clears them by the main flag write or by their edge clear bits
// [RULE19] pin 0 edge cleared either way
// [RULE20] software parses peripheral code for high collection
// [RULE21] wake released after critical flag write
// [RULE22] critical pending bits above reserved nibble
// [RULE23] mask zero accepts, resets to zero
// [RULE24] routing enable moves critical to normal output
// [RULE25] reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module mcip_prioritizer (
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire mcip_pkg::mcip_bus_req_t bus_req,
	output var  logic [31:0]           rd_data,
	input  wire logic [3:0]            irq_pin,
	input  wire logic                  fixed_top_timer,
	input  wire logic                  slice_timer1,
	input  wire logic                  rtc_periodic,
	input  wire logic                  rtc_stopwatch,
	input  wire logic [7:0]            gpio_std_src,
	input  wire logic [7:0]            gpio_wkup_src,
	input  wire logic [7:0]            timer_source,
	input  wire logic                  deep_sleep_wake,
	input  wire logic [21:0]           periph_src,
	input  wire logic [21:0]           periph_mask,
	input  wire logic [21:0][3:0]      periph_prio,
	output var  logic                  core_int,
	output var  logic                  mgmt_irq_output,
	output var  logic                  crit_int,
	output var  logic                  sleep_release,
	output var  logic                  wake_request
);
	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	logic [31:0] ext_ctrl_reg, crit_mask_reg, pri_lo_reg, pri_hi_reg;
	logic        wr_ext, wr_cmask, wr_plo, wr_phi, wr_enc;
	logic        per_reeval, main_reeval, cse_reeval;
	logic [3:0]  edge_indication_clear;

	assign wr_ext      = bus_req.wr && bus_req.addr == mcip_pkg::OFS_EXT_CTRL;
	assign wr_cmask    = bus_req.wr && bus_req.addr == mcip_pkg::OFS_CRIT_MASK;
	assign wr_plo      = bus_req.wr && bus_req.addr == mcip_pkg::OFS_MAIN_PRI_LO;
	assign wr_phi      = bus_req.wr && bus_req.addr == mcip_pkg::OFS_MAIN_PRI_HI;
	assign wr_enc      = bus_req.wr && bus_req.addr == mcip_pkg::OFS_ENC_STAT;
	assign per_reeval  = wr_enc && bus_req.wdata[mcip_pkg::PSE_FLAG]; // [RULE13]
	assign main_reeval = wr_enc && bus_req.wdata[mcip_pkg::MSE_FLAG]; // [RULE14]
	assign cse_reeval  = wr_enc && bus_req.wdata[mcip_pkg::CSE_FLAG]; // [RULE16]
	// clear strobes are never stored; edge clear bits read back as zero, the flag bits read back the encoded valid bits

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_ctrl_reg <= mcip_pkg::EXT_CTRL_RST;
		end else if (wr_ext) begin
			ext_ctrl_reg <= bus_req.wdata & mcip_pkg::EXT_CTRL_WMASK; // [RULE25]
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crit_mask_reg <= mcip_pkg::CRIT_MASK_RST; // [RULE23]
		end else if (wr_cmask) begin
			crit_mask_reg <= bus_req.wdata & mcip_pkg::CRIT_MASK_WMASK; // [RULE25]
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pri_lo_reg <= mcip_pkg::MAIN_PRI_RST;
			pri_hi_reg <= mcip_pkg::MAIN_PRI_RST;
		end else begin
			if (wr_plo) begin
				pri_lo_reg <= bus_req.wdata;
			end
			if (wr_phi) begin
				pri_hi_reg <= bus_req.wdata;
			end
		end
	end

	logic       ext_master_enable, ceb;
	logic [3:0] ext_pin_enable;
	assign ext_master_enable = ext_ctrl_reg[mcip_pkg::MEE_BIT];
	assign ceb = ext_ctrl_reg[mcip_pkg::CEB_BIT];

	// ---------------------------------------------------------------
	// external pin sensing
	// ---------------------------------------------------------------
	logic [3:0] pin_s1_reg, pin_s2_reg, pin_prev_reg, edge_ind_reg, pin_ind;
	logic [3:0] flag_clr;
	logic       main_cur_vld_reg;
	logic [4:0] main_cur_idx_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_reg   <= 4'h0;
			pin_s2_reg   <= 4'h0;
			pin_prev_reg <= 4'h0;
		end else begin
			pin_s1_reg   <= irq_pin;
			pin_s2_reg   <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
		end
	end

	// pin 0 clears through the critical flag, pins 1-3 through the main flag
	assign flag_clr[0] = cse_reeval; // [RULE19]

	genvar p;
	generate
		for (p = 0; p < mcip_pkg::N_PIN; p++) begin : g_pin
			logic [1:0] et;
			logic       hit;
			assign ext_pin_enable[p] = ext_ctrl_reg[mcip_pkg::EXT_PIN_ENABLE_TOP - p];
			assign edge_indication_clear[p] = wr_ext && bus_req.wdata[mcip_pkg::EDGE_INDICATION_CLEAR_TOP - p];
			assign et      = ext_ctrl_reg[mcip_pkg::ETYPE_TOP - 2*p -: 2];
			assign hit = (et == mcip_pkg::ET_RISE) ? (pin_s2_reg[p] && !pin_prev_reg[p])
				: (pin_s2_reg[p] == 1'b0 && pin_prev_reg[p] == 1'b1);
			if (p > 0) begin : g_mclr
				// only the pin that is current is cleared by the main flag
				assign flag_clr[p] = main_reeval && main_cur_vld_reg
					&& main_cur_idx_reg == 5'(p); // [RULE18]
			end
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					edge_ind_reg[p] <= 1'b0;
				end else if (ext_master_enable && hit && et[0] != et[1]) begin
					edge_ind_reg[p] <= 1'b1; // set beats a same-cycle clear
				end else if (edge_indication_clear[p] || flag_clr[p]) begin
					edge_ind_reg[p] <= 1'b0;
				end
			end
			always_comb begin
				unique case (et)
					mcip_pkg::ET_LEVEL_HI: pin_ind[p] = ext_master_enable && pin_s2_reg[p];
					mcip_pkg::ET_LEVEL_LO: pin_ind[p] = ext_master_enable && !pin_s2_reg[p];
					default:               pin_ind[p] = edge_ind_reg[p];
				endcase
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	// strict greater-than keeps the lowest index among equal keys
	function automatic logic [5:0] pick_best(input logic [21:0] act,
		input logic [21:0][4:0] key);
		logic [4:0] bk;
		logic [4:0] bi;
		logic       fnd;
		bk  = 5'h0;
		bi  = 5'h0;
		fnd = 1'b0;
		for (int i = 0; i < 22; i++) begin
			if (act[i] && (!fnd || key[i] > bk)) begin
				fnd = 1'b1;
				bk  = key[i];
				bi  = 5'(i);
			end
		end
		return {fnd, bi};
	endfunction

	// ---------------------------------------------------------------
	// peripheral group
	// ---------------------------------------------------------------
	logic [21:0]      per_act, per_high;
	logic [21:0][4:0] per_key;
	logic             low_coll, high_coll, per_cur_vld_reg;
	logic [4:0]       per_cur_idx_reg;
	logic [5:0]       per_pick, periph_encoded_status;

	genvar q;
	generate
		for (q = 0; q < mcip_pkg::N_PERI; q++) begin : g_per
			assign per_act[q]  = periph_src[q] && !periph_mask[q];
			assign per_high[q] = (q == 0) || periph_prio[q][3];
			assign per_key[q]  = (q == 0) ? 5'h10 : {1'b0, periph_prio[q]};
		end
	endgenerate

	assign low_coll  = |(per_act & ~per_high); // [RULE8]
	assign high_coll = |(per_act & per_high); // [RULE8]
	assign per_pick  = pick_best(per_act, per_key);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			per_cur_vld_reg <= 1'b0;
			per_cur_idx_reg <= 5'h0;
		end else if (per_reeval || !per_cur_vld_reg || !per_act[per_cur_idx_reg]) begin
			per_cur_vld_reg <= per_pick[5]; // [RULE12] [RULE13]
			per_cur_idx_reg <= per_pick[4:0];
		end
	end
	assign periph_encoded_status = {per_cur_vld_reg, per_cur_idx_reg}; // [RULE11]

	// ---------------------------------------------------------------
	// main group
	// ---------------------------------------------------------------
	logic [16:0]      main_raw, main_act, main_bank, main_mask;
	logic [21:0][4:0] main_key;
	logic [5:0]       main_pick, main_encoded_status;

	assign main_raw = {timer_source, |gpio_wkup_src, |gpio_std_src, rtc_stopwatch,
		rtc_periodic, low_coll, pin_ind[3:1], fixed_top_timer}; // [RULE9]

	genvar m;
	generate
		for (m = 0; m < mcip_pkg::N_MAIN; m++) begin : g_main
			logic [3:0] pri;
			assign main_mask[m] = crit_mask_reg[mcip_pkg::MASK_TOP - m]; // [RULE1]
			if (m == 0) begin : g_fix
				assign pri          = 4'h0;
				assign main_bank[m] = 1'b1; // [RULE4]
				assign main_key[m]  = 5'h10; // [RULE4]
			end else begin : g_prog
				if (m <= 8) begin : g_lo
					assign pri = pri_lo_reg[31 - 4*(m-1) -: 4]; // [RULE7]
				end else begin : g_hi
					assign pri = pri_hi_reg[31 - 4*(m-9) -: 4]; // [RULE7]
				end
				assign main_bank[m] = pri[3]; // [RULE5]
				assign main_key[m]  = {1'b0, pri}; // [RULE5] [RULE6]
			end
			if (m >= 1 && m <= 3) begin : g_ext
				assign main_act[m] = main_raw[m] && !main_mask[m] && ext_pin_enable[m]; // [RULE3]
			end else begin : g_plain
				assign main_act[m] = main_raw[m] && !main_mask[m]; // [RULE2] [RULE23]
			end
		end
		for (m = mcip_pkg::N_MAIN; m < 22; m++) begin : g_pad
			assign main_key[m] = 5'h0;
		end
	endgenerate

	assign main_pick = pick_best({5'h0, main_act}, main_key);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			main_cur_vld_reg <= 1'b0;
			main_cur_idx_reg <= 5'h0;
		end else if (main_reeval || !main_cur_vld_reg || !main_act[main_cur_idx_reg]) begin
			main_cur_vld_reg <= main_pick[5]; // [RULE12] [RULE14]
			main_cur_idx_reg <= main_pick[4:0];
		end
	end
	assign main_encoded_status = {main_cur_vld_reg, main_cur_idx_reg}; // [RULE14]

	// ---------------------------------------------------------------
	// critical group
	// ---------------------------------------------------------------
	logic [3:0]       crit_raw, crit_act;
	logic [21:0][4:0] crit_key;
	logic [5:0]       crit_pick;
	logic             crit_cur_vld_reg;
	logic [1:0]       crit_cur_idx_reg;
	logic [2:0]       crit_encoded_status;

	// pin 0 pending needs only the master enable; the core needs its own enable too
	assign crit_raw = {deep_sleep_wake, high_coll, slice_timer1, pin_ind[0]}; // [RULE16]
	assign crit_act = crit_raw & {3'h7, ext_pin_enable[0]};

	genvar c;
	generate
		for (c = 0; c < 22; c++) begin : g_ckey
			if (c < mcip_pkg::N_CRIT) begin : g_k
				assign crit_key[c] = {3'h0, crit_mask_reg[mcip_pkg::CPRI_TOP - 2*c -: 2]};
			end else begin : g_z
				assign crit_key[c] = 5'h0;
			end
		end
	endgenerate

	assign crit_pick = pick_best({18'h0, crit_act}, crit_key);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crit_cur_vld_reg <= 1'b0;
			crit_cur_idx_reg <= 2'h0;
		end else if (cse_reeval || !crit_cur_vld_reg || !crit_act[crit_cur_idx_reg]) begin
			crit_cur_vld_reg <= crit_pick[5]; // [RULE12] [RULE16]
			crit_cur_idx_reg <= crit_pick[1:0];
		end
	end
	assign crit_encoded_status = {crit_cur_vld_reg, crit_cur_idx_reg};

	// ---------------------------------------------------------------
	// core outputs
	// ---------------------------------------------------------------
	logic crit_any;
	assign crit_any = |crit_act;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_int        <= 1'b0;
			crit_int        <= 1'b0;
			mgmt_irq_output <= 1'b0;
		end else begin
			core_int        <= |(main_act & ~main_bank) || (ceb && crit_any); // [RULE24]
			crit_int        <= !ceb && crit_any; // [RULE24]
			mgmt_irq_output <= |(main_act & main_bank); // [RULE4] [RULE5]
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_release <= 1'b0;
			wake_request  <= 1'b0;
		end else begin
			sleep_release <= cse_reeval; // [RULE21]
			wake_request  <= |gpio_wkup_src || |timer_source[7:6]; // [RULE10]
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	logic [31:0] rd_next;
	always_comb begin
		rd_next = 32'h0;
		unique case (bus_req.addr)
			mcip_pkg::OFS_EXT_CTRL:    rd_next = ext_ctrl_reg;
			mcip_pkg::OFS_CRIT_MASK:   rd_next = crit_mask_reg;
			mcip_pkg::OFS_MAIN_PRI_LO: rd_next = pri_lo_reg;
			mcip_pkg::OFS_MAIN_PRI_HI: rd_next = pri_hi_reg;
			mcip_pkg::OFS_ENC_STAT: begin
				rd_next[mcip_pkg::PSE_LSB +: 6] = periph_encoded_status;
				rd_next[mcip_pkg::MSE_LSB +: 6] = main_encoded_status;
				rd_next[mcip_pkg::CSE_LSB +: 3] = crit_encoded_status;
				rd_next[mcip_pkg::CEB_BIT]      = ceb; // [RULE17]
			end
			mcip_pkg::OFS_CRIT_ALL: begin
				for (int i = 0; i < mcip_pkg::N_CRIT; i++) begin
					rd_next[mcip_pkg::CSA_TOP - i] = crit_raw[i]; // [RULE22]
				end
			end
			mcip_pkg::OFS_MAIN_ALL: begin
				for (int i = 0; i < mcip_pkg::N_MAIN; i++) begin
					rd_next[mcip_pkg::MASK_TOP - i] = main_raw[i]; // [RULE2]
				end
			end
			default: rd_next = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 32'h0;
		end else begin
			rd_data <= bus_req.rd ? rd_next : 32'h0; // [RULE25]
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_wake_ack;
		cse_reeval ##1 sleep_release;
	endsequence

	a_mask_hides_main: assert property ((&main_mask)[*2] |-> !main_cur_vld_reg) // [RULE2]
		else $error("masked main source became current");
	a_ext_enable_gate: assert property ((ext_pin_enable[3:1] == 3'h0)[*2]
		|-> !(main_cur_vld_reg && main_cur_idx_reg inside {5'h1, 5'h2, 5'h3})) // [RULE3]
		else $error("disabled pin became current");
	a_fixed_top_wins: assert property ((main_act[0] && !main_cur_vld_reg)
		|=> main_cur_vld_reg && main_cur_idx_reg == 5'h0) // [RULE4]
		else $error("fixed timer did not win");
	a_bank_to_mgmt: assert property ((main_act[1] && main_bank[1])
		|=> mgmt_irq_output) // [RULE5]
		else $error("bank one source missed management output");
	a_periph_flag_code: assert property ((per_cur_vld_reg && per_cur_idx_reg == 5'h0)
		|-> periph_encoded_status == 6'h20) // [RULE11]
		else $error("peripheral zero code wrong");
	a_hold_current: assert property ((main_cur_vld_reg && main_act[main_cur_idx_reg]
		&& !main_reeval) |=> main_cur_vld_reg && $stable(main_cur_idx_reg)) // [RULE12]
		else $error("current main changed while held");
	a_main_reeval: assert property ((main_reeval && main_act == 17'h0)
		|=> !main_cur_vld_reg) // [RULE14]
		else $error("main re-evaluation kept stale source");
	a_crit_route: assert property ((crit_any && ceb) |=> core_int && !crit_int) // [RULE24]
		else $error("critical routing not applied");
	a_sleep_release: assert property (cse_reeval |-> s_wake_ack) // [RULE21]
		else $error("wake release missing after flag write");
	a_release_cause: assert property (sleep_release |-> $past(cse_reeval)) // [RULE21]
		else $error("wake release without flag write");
	a_mirror_read: assert property ((bus_req.rd && bus_req.addr == mcip_pkg::OFS_ENC_STAT)
		|=> rd_data[0] == $past(ceb)) // [RULE17]
		else $error("routing mirror wrong");
	a_crit_reserved: assert property ((bus_req.rd && bus_req.addr == mcip_pkg::OFS_CRIT_ALL)
		|=> rd_data[31:28] == 4'h0 && rd_data[23:0] == 24'h0) // [RULE22]
		else $error("critical pending reserved bits set");
endmodule
`default_nettype wire

// ==== tb/mcip_src_model.sv ====
/*
 * source-module model: each bit is one interrupt source that holds its
 * level request until the service routine clears it at the source.
 * assumes: set and clear pulses come from the bench on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mcip_src_model #(
	parameter int W = 51
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] set_vec,
	input  wire logic [W-1:0] clr_vec,
	output var  logic [W-1:0] irq_out
);
	// ---------------------------------------------------------------
	// level requests
	// ---------------------------------------------------------------
	// level stays up until cleared at the source, never self-negates
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_out <= '0;
		end else begin
			irq_out <= (irq_out | set_vec) & ~clr_vec;
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * self-checking bench for the main/critical interrupt prioritizer.
 * assumes: mcip_pkg and mcip_prioritizer compiled first; sources come
 * from mcip_src_model, registers through the plain strobe port.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [11:0] ENC = mcip_pkg::OFS_ENC_STAT;
	localparam logic [11:0] MSK = mcip_pkg::OFS_CRIT_MASK;
	localparam logic [11:0] EXT = mcip_pkg::OFS_EXT_CTRL;
	logic                    ref_clk = 1'b0;
	logic                    arst_n = 1'b0;
	mcip_pkg::mcip_bus_req_t bus_req = '0;
	logic [31:0]             rd_data;
	logic [3:0]              irq_pin = '0;
	logic [21:0]             periph_mask = '0;
	logic [21:0][3:0]        periph_prio = '0;
	logic [50:0]             set_vec = '0;
	logic [50:0]             clr_vec = '0;
	logic [50:0]             s_irq;
	logic                    core_int, mgmt_irq_output, crit_int;
	logic                    sleep_release, wake_request;
	logic [31:0]             lo_pri = '0, hi_pri = '0;
	int                      errors = 0, num_checks = 0;

	always #2 ref_clk = ~ref_clk;

	mcip_src_model #(.W(51)) mcip_src_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.set_vec(set_vec), .clr_vec(clr_vec), .irq_out(s_irq));

	mcip_prioritizer mcip_prioritizer_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.bus_req(bus_req), .rd_data(rd_data), .irq_pin(irq_pin),
		.fixed_top_timer(s_irq[0]), .slice_timer1(s_irq[1]), .rtc_periodic(s_irq[2]),
		.rtc_stopwatch(s_irq[3]), .gpio_std_src(s_irq[11:4]), .gpio_wkup_src(s_irq[19:12]),
		.timer_source(s_irq[27:20]), .deep_sleep_wake(s_irq[28]),
		.periph_src(s_irq[50:29]), .periph_mask(periph_mask), .periph_prio(periph_prio),
		.core_int(core_int), .mgmt_irq_output(mgmt_irq_output), .crit_int(crit_int),
		.sleep_release(sleep_release), .wake_request(wake_request));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
			input string msg);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(rd_data & m, e, msg);
	endtask

	// source module raises or drops, then the answer gets time to land
	task automatic src(input int i, input bit on);
		@(posedge ref_clk);
		if (on) begin
			set_vec[i] <= 1'b1;
		end else begin
			clr_vec[i] <= 1'b1;
		end
		@(posedge ref_clk);
		set_vec <= '0;
		clr_vec <= '0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic pri(input int k, input logic [3:0] v);
		if (k <= 8) begin
			lo_pri[35-4*k -: 4] = v;
			wr(mcip_pkg::OFS_MAIN_PRI_LO, lo_pri);
		end else begin
			hi_pri[67-4*k -: 4] = v;
			wr(mcip_pkg::OFS_MAIN_PRI_HI, hi_pri);
		end
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		arst_n <= 1'b0;
		irq_pin <= '0;
		periph_prio <= '0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		lo_pri = '0;
		hi_pri = '0;
		@(posedge ref_clk);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rchk(mcip_pkg::OFS_MAIN_PRI_LO, 32'h0, 32'hffffffff, "pri lo reset");
		rchk(MSK, 32'h0, 32'hffffffff, "mask reset");
		rchk(mcip_pkg::OFS_CRIT_ALL, 32'h0, 32'hffffffff, "crit all reset");
		rchk(12'h600, 32'h0, 32'hffffffff, "unmapped read");
		wr(MSK, 32'hffffffff);
		rchk(MSK, 32'hff01ffff, 32'hffffffff, "mask reserved");
		pri(1, 4'h3);
		pri(8, 4'hc);
		pri(9, 4'h5);
		pri(16, 4'ha);
		rchk(mcip_pkg::OFS_MAIN_PRI_LO, 32'h3000000c, 32'hffffffff, "nibble lo");
		rchk(mcip_pkg::OFS_MAIN_PRI_HI, 32'h5000000a, 32'hffffffff, "nibble hi");
	endtask

	task automatic t_prio();
		src(20, 1);
		src(21, 1);
		wr(ENC, 32'h00200000);
		rchk(ENC, 32'h00290000, 32'h003f0000, "tie to lower");
		chk(32'(core_int), 32'h1, "core int bank0");
		pri(10, 4'h5);
		rchk(ENC, 32'h00290000, 32'h003f0000, "hold current");
		wr(ENC, 32'h00200000);
		rchk(ENC, 32'h002a0000, 32'h003f0000, "main reeval");
		src(21, 0);
		rchk(ENC, 32'h00290000, 32'h003f0000, "auto reeval");
		pri(9, 4'h8);
		chk({30'h0, mgmt_irq_output, core_int}, 32'h2, "bank1 to mgmt");
	endtask

	task automatic t_mask();
		wr(MSK, 32'h00000080);
		src(20, 1);
		chk(32'(core_int), 32'h0, "masked core");
		rchk(ENC, 32'h0, 32'h003f0000, "masked code");
		rchk(mcip_pkg::OFS_MAIN_ALL, 32'h80, 32'h1ffff, "masked pending");
		wr(MSK, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk(32'(core_int), 32'h1, "unmasked core");
		pri(9, 4'h7);
		src(0, 1);
		wr(ENC, 32'h00200000);
		rchk(ENC, 32'h00200000, 32'h003f0000, "source0 top");
		chk(32'(mgmt_irq_output), 32'h1, "source0 mgmt");
	endtask

	task automatic t_periph();
		periph_prio[3] <= 4'h2;
		src(32, 1);
		rchk(ENC, 32'h23240000, 32'h3f3f0000, "low collection");
		src(29, 1);
		rchk(ENC, 32'h00000600, 32'h00000700, "high collection");
		rchk(mcip_pkg::OFS_CRIT_ALL, 32'h02000000, 32'hffffffff, "crit pending");
		chk(32'(crit_int), 32'h1, "crit out");
		wr(ENC, 32'h20000000);
		rchk(ENC, 32'h20000000, 32'h3f000000, "periph reeval");
	endtask

	task automatic t_crit();
		int n;
		n = 0;
		wr(EXT, 32'h1);
		rchk(ENC, 32'h1, 32'h1, "route mirror");
		src(1, 1);
		rchk(ENC, 32'h00000500, 32'h00000700, "slice timer code");
		chk({30'h0, core_int, crit_int}, 32'h2, "crit on core");
		src(1, 0);
		src(28, 1);
		rchk(ENC, 32'h00000700, 32'h00000700, "wake code");
		wr(ENC, 32'h00000400);
		repeat (3) begin
			#1;
			n += int'(sleep_release === 1'b1);
			@(posedge ref_clk);
		end
		chk(n, 1, "release pulse");
	endtask

	task automatic t_pins();
		int n;
		n = 0;
		wr(EXT, 32'h00001000);
		irq_pin <= 4'b0010;
		repeat (8) @(posedge ref_clk);
		chk(32'(core_int), 32'h0, "pin disabled");
		wr(MSK, 32'h00008000);
		wr(EXT, 32'h00001400);
		repeat (8) @(posedge ref_clk);
		chk(32'(core_int), 32'h0, "pin masked");
		wr(MSK, 32'h0);
		while (core_int !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 10) begin
			errors++;
			print_verdict();
		end
		rchk(ENC, 32'h00210000, 32'h003f0000, "pin code");
	endtask

	task automatic t_gpio();
		src(7, 1);
		rchk(ENC, 32'h00270000, 32'h003f0000, "std pins");
		src(7, 0);
		src(17, 1);
		rchk(ENC, 32'h00280000, 32'h003f0000, "wake pins");
		chk(32'(wake_request), 32'h1, "wake pins wake");
		src(17, 0);
		src(27, 1);
		rchk(ENC, 32'h00300000, 32'h003f0000, "last timer");
		chk(32'(wake_request), 32'h1, "timer wake");
	endtask

	// pin 0 falls, pin 1 rises; each edge latch cleared by its own method
	task automatic t_edge();
		irq_pin <= 4'h1;
		wr(EXT, 32'h00901c00);
		repeat (2) @(posedge ref_clk);
		irq_pin <= 4'h2;
		repeat (5) @(posedge ref_clk);
		rchk(ENC, 32'h00210400, 32'h003f0700, "edges latched");
		wr(ENC, 32'h00200000);
		rchk(ENC, 32'h00000400, 32'h003f0700, "main flag clear");
		wr(EXT, 32'h08901c00);
		rchk(ENC, 32'h0, 32'h003f0700, "pin0 edge clear");
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		do_reset();
		t_prio();
		do_reset();
		t_mask();
		do_reset();
		t_periph();
		do_reset();
		t_crit();
		do_reset();
		t_pins();
		do_reset();
		t_gpio();
		do_reset();
		t_edge();
		print_verdict();
	end
endmodule
`default_nettype wire
